//--- tscs_map.vh
`ifndef TSCS_MAP_VH
`define TSCS_MAP_VH
// oscillator mode encodings
`define TSCS_MODE_W        3
`define TSCS_MODE_LP       3'h0
`define TSCS_MODE_XT       3'h1
`define TSCS_MODE_HS       3'h2
`define TSCS_MODE_EXTCLK   3'h3
`define TSCS_MODE_INTERNAL_RC_OSCILLATOR   3'h4
// start-up oscillation count
`define TSCS_OST_COUNT     1024
`define TSCS_OST_W         11
// clock select encodings
`define TSCS_SEL_INT       1'h0
`define TSCS_SEL_EXT       1'h1
// reset values
`define TSCS_FLAG_RST      1'h0
`endif

//--- tscs_osc_counter.v
`timescale 1ns/10ps
`default_nettype none
`include "tscs_map.vh"
// ****************************************
// oscillation counter on synced edges
// ****************************************
module tscs_osc_counter #(
	parameter integer COUNT = `TSCS_OST_COUNT,
	parameter integer CW    = `TSCS_OST_W
) (
	// clock and reset
	input  wire ref_clk,
	input  wire rst_b,
	// control
	input  wire clear,
	input  wire run,
	input  wire osc_edge,
	// status
	output reg  done_q
);
	reg [CW-1:0] cnt_q;

	// counts edges while running; clear has priority so each start is from zero
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q  <= {CW{1'h0}};
			done_q <= 1'h0;
		end else if (clear) begin
			cnt_q  <= {CW{1'h0}};
			done_q <= 1'h0;
		end else if (run && osc_edge && !done_q) begin
			if (cnt_q == COUNT[CW-1:0] - 1'h1) begin
				done_q <= 1'h1;
			end
			cnt_q <= cnt_q + 1'h1;
		end
	end
endmodule // tscs_osc_counter
`default_nettype wire

//--- tscs_clock_startup.v
`timescale 1ns/10ps
`default_nettype none
`include "tscs_map.vh"
// Overview of operation
// - The pll ready flag sets once the switch to the 32 MHz pll clock is done and clears once the switch back is done; here it clears when pll_req drops.
// - In the three crystal modes the oscillation counter runs and needs 1024 oscillations before the crystal may clock the system.
// - During two-speed start-up the core runs from the internal oscillator at once after waking.
// - In any non-crystal mode two-speed start-up is off and no stabilisation wait applies.
// - Reaching 1024 before sleep sets the external running flag and moves the core to the external oscillator.
// - Entering sleep during the count aborts it and leaves the external running flag clear.
module tscs_clock_startup #(
	parameter integer OST_COUNT = `TSCS_OST_COUNT
) (
	// clock and reset
	input  wire                    ref_clk,
	input  wire                    rst_b,
	// configuration
	input  wire [`TSCS_MODE_W-1:0] osc_mode,
	// core events
	input  wire                    sleep_exec,
	input  wire                    wake_event,
	// pll switching
	input  wire                    pll_req,
	input  wire                    pll_locked,
	// external oscillator, asynchronous
	input  wire                    ext_osc_in,
	// status and selection
	output reg                     ext_osc_running_flag,
	output reg                     pll_ready_flag,
	output reg                     sys_clk_sel_ext,
	output reg                     core_run,
	output reg                     ost_active
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	reg osc_s1_q;
	reg osc_s2_q;
	reg osc_s3_q;
	reg lock_s1_q;
	reg lock_s2_q;

	// crystal pin: two stages before use, third only for the edge detect;
	// all reset low, the level of a stopped crystal, so no false edge after reset
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			osc_s1_q <= 1'h0;
			osc_s2_q <= 1'h0;
			osc_s3_q <= 1'h0;
		end else begin
			osc_s1_q <= ext_osc_in;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
		end
	end

	// pll lock arrives from the pll's own clock
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_s1_q <= 1'h0;
			lock_s2_q <= 1'h0;
		end else begin
			lock_s1_q <= pll_locked;
			lock_s2_q <= lock_s1_q;
		end
	end

	// one pulse per rising crystal edge; a crystal above half of ref_clk loses edges
	wire osc_edge = osc_s2_q & ~osc_s3_q;

	// ****************************************
	// mode decode and sequencing
	// ****************************************
	wire crystal_mode = (osc_mode == `TSCS_MODE_LP) || (osc_mode == `TSCS_MODE_XT) ||
	                    (osc_mode == `TSCS_MODE_HS);

	localparam [3:0] ST_START = 4'h1;
	localparam [3:0] ST_QUAL  = 4'h2;
	localparam [3:0] ST_RUN   = 4'h4;
	localparam [3:0] ST_SLEEP = 4'h8;

	reg  [3:0] state_q, state_d;
	reg        cnt_clear;
	wire       cnt_done;

	// core runs during qualification; sleep abandons the count
	always @* begin
		state_d   = state_q;
		cnt_clear = 1'h0;
		case (state_q)
			ST_START: begin
				cnt_clear = 1'h1;
				state_d   = crystal_mode ? ST_QUAL : ST_RUN;
			end
			ST_QUAL: begin
				if (sleep_exec) begin
					state_d = ST_SLEEP;
				end else if (cnt_done) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (sleep_exec) begin
					state_d = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				cnt_clear = 1'h1;
				if (wake_event) begin
					state_d = ST_START;
				end
			end
			default: begin
				state_d = ST_START;
			end
		endcase
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_START;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// oscillation counter
	// ****************************************
	tscs_osc_counter #(
		.COUNT (OST_COUNT),
		.CW    (`TSCS_OST_W)
	) u_cnt (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.clear    (cnt_clear),
		.run      (state_q == ST_QUAL),
		.osc_edge (osc_edge),
		.done_q   (cnt_done)
	);

	// ****************************************
	// status outputs
	// ****************************************
	reg ost_active_d;
	reg core_run_d;
	reg ext_run_d;
	reg sel_ext_d;

	// decoded from the next state so every output lines up with state_q
	always @* begin
		ost_active_d = (state_d == ST_QUAL);
		core_run_d   = (state_d == ST_QUAL) || (state_d == ST_RUN);
		ext_run_d    = `TSCS_FLAG_RST;
		sel_ext_d    = `TSCS_SEL_INT;
		if (state_d == ST_RUN) begin
			// no wait outside crystal modes, but the flag only means a qualified crystal
			sel_ext_d = `TSCS_SEL_EXT;
			ext_run_d = crystal_mode;
		end
	end

	// qualification in progress
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ost_active <= `TSCS_FLAG_RST;
		end else begin
			ost_active <= ost_active_d;
		end
	end

	// core keeps running during qualification; only sleep stops it
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			core_run <= `TSCS_FLAG_RST;
		end else begin
			core_run <= core_run_d;
		end
	end

	// set only by a completed count; sleep clears it so each wake requalifies
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ext_osc_running_flag <= `TSCS_FLAG_RST;
		end else begin
			ext_osc_running_flag <= ext_run_d;
		end
	end

	// external source only after qualification or in a mode with nothing to wait for
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sys_clk_sel_ext <= `TSCS_SEL_INT;
		end else begin
			sys_clk_sel_ext <= sel_ext_d;
		end
	end

	// ****************************************
	// pll ready
	// ****************************************
	reg pll_ready_d;

	// set once synced lock meets the request, cleared as soon as the request drops;
	// switch back taken as immediate, so firmware may sleep right after reading zero
	always @* begin
		pll_ready_d = pll_ready_flag;
		if (pll_req && lock_s2_q) begin
			pll_ready_d = 1'h1;
		end else if (!pll_req) begin
			pll_ready_d = 1'h0;
		end
	end

	// flag polled by firmware before sleep
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pll_ready_flag <= `TSCS_FLAG_RST;
		end else begin
			pll_ready_flag <= pll_ready_d;
		end
	end
endmodule // tscs_clock_startup
`default_nettype wire

//--- tscs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// **
// startup checker
// **
module tscs_monitor #(
	parameter integer OST_COUNT = 1024
) (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_b,
	// block inputs
	input wire logic [2:0] osc_mode,
	input wire logic       sleep_exec,
	input wire logic       wake_event,
	input wire logic       pll_req,
	input wire logic       pll_locked,
	input wire logic       ext_osc_in,
	// block outputs
	input wire logic       ext_osc_running_flag,
	input wire logic       pll_ready_flag,
	input wire logic       sys_clk_sel_ext,
	input wire logic       core_run,
	input wire logic       ost_active
);
	logic p_q;
	int   n_q;
	// raw crystal edges during qualification; slow crystal keeps this exact
	always @(posedge ref_clk) begin
		p_q <= ext_osc_in;
		n_q <= !ost_active ? 0 : n_q + (ext_osc_in && !p_q);
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence s_pll_on;
		(pll_req && pll_locked) [*5];
	endsequence
	a_pll_ready: assert property (s_pll_on |-> pll_ready_flag) else $error("pll flag late");
	a_pll_drop: assert property (!pll_req |=> !pll_ready_flag) else $error("pll flag stuck");
	a_ost_count: assert property ($rose(ext_osc_running_flag) |-> n_q == OST_COUNT) else $error("bad count");
	a_xtal_only: assert property (osc_mode > 3'h2 |-> !ost_active && !ext_osc_running_flag) else $error("qual");
	a_ext_switch: assert property ($rose(ext_osc_running_flag) |-> sys_clk_sel_ext && $past(ost_active))
		else $error("switch wrong");
	a_int_hold: assert property (ost_active |-> core_run && !sys_clk_sel_ext) else $error("left internal");
	a_sleep_abort: assert property (sleep_exec && ost_active |=> !ost_active && !ext_osc_running_flag)
		else $error("no abort");
endmodule // tscs_monitor
bind tscs_clock_startup tscs_monitor #(
	.OST_COUNT (OST_COUNT)
) u_mon (
	.ref_clk              (ref_clk),
	.rst_b                (rst_b),
	.osc_mode             (osc_mode),
	.sleep_exec           (sleep_exec),
	.wake_event           (wake_event),
	.pll_req              (pll_req),
	.pll_locked           (pll_locked),
	.ext_osc_in           (ext_osc_in),
	.ext_osc_running_flag (ext_osc_running_flag),
	.pll_ready_flag       (pll_ready_flag),
	.sys_clk_sel_ext      (sys_clk_sel_ext),
	.core_run             (core_run),
	.ost_active           (ost_active)
);
`default_nettype wire

//--- tscs_xtal_model.sv
`timescale 1ns/10ps
`default_nettype none
// **
// crystal model
// **
module tscs_xtal_model (
	input wire logic run,
	output var logic osc
);
	initial osc = 1'b0;
	// stopped crystal rests low; period unrelated to ref_clk
	always #101 osc = run ? !osc : 1'b0;
endmodule // tscs_xtal_model
`default_nettype wire

//--- tb_two_speed_clock_startup.sv
`timescale 1ns/10ps
`default_nettype none
// **
// bench
// **
module tb_two_speed_clock_startup;
	logic ref_clk = 0, rst_b = 0, sleep_exec = 0, wake_event = 0, pll_req = 0, pll_locked = 0, xen = 1;
	logic [2:0] osc_mode = 3'h0;
	wire ext_osc_in, ext_osc_running_flag, pll_ready_flag, sys_clk_sel_ext, core_run, ost_active;
	int errors = 0, checks = 0, cyc = 0, i;
	// mode, expected flag, expected selection
	logic [4:0] rows [5] = '{5'h03, 5'h07, 5'h0B, 5'h0D, 5'h11};
	always #12.5 ref_clk = !ref_clk;
	tscs_clock_startup #(.OST_COUNT(4)) DUT (.*);
	tscs_xtal_model u_xtal (.run(ost_active && xen), .osc(ext_osc_in));
	task print_verdict;
		if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task ck(input string n, input logic e, input logic s);
		checks++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s exp %b got %b", n, e, s);
		end
	endtask
	task rs(input logic [2:0] m);
		rst_b = 0;
		osc_mode = m;
		repeat (16) @(negedge ref_clk);
		rst_b = 1;
		repeat (3) @(negedge ref_clk);
	endtask
	task pulse_sleep;
		sleep_exec = 1;
		@(negedge ref_clk);
		sleep_exec = 0;
		@(negedge ref_clk);
	endtask
	task pulse_wake;
		wake_event = 1;
		@(negedge ref_clk);
		wake_event = 0;
	endtask
	// bounded wait, crystal needs about eight cycles an edge
	task wt;
		for (i = 0; i < 300 && ext_osc_running_flag !== 1'b1; i++) @(negedge ref_clk);
	endtask
	// hang guard
	always @(posedge ref_clk) if (++cyc > 20000) begin
		errors++;
		print_verdict;
	end
	initial begin
		foreach (rows[r]) begin
			rs(rows[r][4:2]);
			ck("sel0", rows[r][0] & !rows[r][1], sys_clk_sel_ext);
			ck("run", 1, core_run);
			wt;
			ck("flag", rows[r][1], ext_osc_running_flag);
			ck("sel", rows[r][0], sys_clk_sel_ext);
		end
		// sleep while the crystal is still silent
		xen = 0;
		rs(3'h2);
		ck("qual", 1, ost_active);
		pulse_sleep;
		ck("abort", 0, ost_active | ext_osc_running_flag);
		ck("halt", 0, core_run);
		// wake, count part of the way, then sleep again
		xen = 1;
		pulse_wake;
		repeat (16) @(negedge ref_clk);
		ck("early", 1, ost_active & core_run & !sys_clk_sel_ext);
		pulse_sleep;
		ck("abort2", 0, ext_osc_running_flag);
		// next wake must count again from zero, so no flag after half a count
		pulse_wake;
		repeat (16) @(negedge ref_clk);
		ck("restart", 0, ext_osc_running_flag);
		wt;
		ck("requal", 1, ext_osc_running_flag);
		// firmware waits on the pll flag before sleeping
		pll_req = 1;
		pll_locked = 1;
		repeat (5) @(negedge ref_clk);
		ck("pll_ready_flag", 1, pll_ready_flag);
		pll_req = 0;
		@(negedge ref_clk);
		ck("pllr0", 0, pll_ready_flag);
		pulse_sleep;
		ck("slept", 0, ext_osc_running_flag);
		print_verdict;
	end
endmodule // tb_two_speed_clock_startup
`default_nettype wire
